//--- rtl/ebpwm_deadband.sv
`timescale 1ns/1ps
module ebpwm_deadband
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic db_enable_in,
	input wire logic pwm_in,
	input wire logic [6:0] count_in,
	output logic out_a_out,
	output logic out_b_out
);
	typedef struct packed
	{
		logic [1:0][8:0] cnt;
		logic [1:0] prev;
		logic [1:0] out;
	} ebpwm_dbst_t;
	ebpwm_dbst_t st_r;
	ebpwm_dbst_t st_nxt;
	logic [1:0] src;
	logic [8:0] load;

	always_comb
	begin
		src = {~pwm_in, pwm_in}; // RQ5
		load = 9'(count_in) * 9'(ebpwm_pkg::OSC_PER_TCY); // RQ6
		st_nxt = st_r;
		for (int i = 0; i < 2; i++)
		begin
			st_nxt.prev[i] = src[i];
			if (!db_enable_in || !src[i])
				st_nxt.cnt[i] = 9'h000; // RQ10 RQ25
			else if (!st_r.prev[i])
				st_nxt.cnt[i] = load; // RQ25
			else if (st_r.cnt[i] != 9'h000)
				st_nxt.cnt[i] = st_r.cnt[i] - 9'h001;
			// A delay longer than the pulse simply never lets it out.
			st_nxt.out[i] = src[i] && (st_nxt.cnt[i] == 9'h000); // RQ6 RQ7
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign out_a_out = st_r.out[0];
	assign out_b_out = st_r.out[1];
endmodule : ebpwm_deadband

//--- rtl/ebpwm_pkg.sv
package ebpwm_pkg;
	// -------------------------------------------------
	// Output configuration codes
	// -------------------------------------------------
	localparam logic [1:0] CFG_SINGLE = 2'h0;
	localparam logic [1:0] CFG_FWD = 2'h1;
	localparam logic [1:0] CFG_HALF = 2'h2;
	localparam logic [1:0] CFG_REV = 2'h3;
	localparam int CFG_FULL_BIT = 0;
	localparam int CFG_DIR_BIT = 1;
	// -------------------------------------------------
	// Shutdown source mask and safe-state codes
	// -------------------------------------------------
	localparam int SRC_CMP_BIT = 0;
	localparam int SRC_INT_BIT = 1;
	localparam logic [1:0] SAFE_LOW = 2'h0;
	localparam logic [1:0] SAFE_HIGH = 2'h1;
	localparam int SAFE_HIZ_BIT = 1;
	// -------------------------------------------------
	// Timing, polarity bit positions and run states
	// -------------------------------------------------
	localparam int OSC_PER_TCY = 4;
	localparam int DIR_LEAD_TCY = 4;
	localparam logic [3:0] PRE_LAST_1 = 4'h0;
	localparam logic [3:0] PRE_LAST_4 = 4'h3;
	localparam logic [3:0] PRE_LAST_16 = 4'hf;
	localparam int POL_AC_BIT = 1;
	localparam int POL_BD_BIT = 0;
	typedef enum logic [1:0]
	{
		RUN_OFF = 2'b00,
		RUN_WAIT = 2'b01,
		RUN_ON = 2'b10,
		RUN_SHUT = 2'b11
	} ebpwm_run_t;
endpackage : ebpwm_pkg

//--- rtl/ebpwm_tb_if.sv
`timescale 1ns/1ps
interface ebpwm_tb_if;
	logic enable;
	logic [7:0] period_limit;
	logic [1:0] prescale_sel;
	logic [9:0] fine_count;
	logic period_start;
	logic dir_point;
	modport timer (input enable, input period_limit, input prescale_sel,
		output fine_count, output period_start, output dir_point);
	modport user (output enable, output period_limit, output prescale_sel,
		input fine_count, input period_start, input dir_point);
endinterface : ebpwm_tb_if

//--- rtl/ebpwm_timebase.sv
`timescale 1ns/1ps
module ebpwm_timebase
(
	input wire logic clk_in,
	input wire logic resetn_in,
	ebpwm_tb_if.timer tb
);
	typedef struct packed
	{
		logic [3:0] pre;
		logic [9:0] fine;
	} ebpwm_tbst_t;
	ebpwm_tbst_t st_r;
	ebpwm_tbst_t st_nxt;
	logic [3:0] pre_last;
	logic [7:0] dir_tmr;

	always_comb
	begin
		case (tb.prescale_sel)
			2'h0: pre_last = ebpwm_pkg::PRE_LAST_1;
			2'h1: pre_last = ebpwm_pkg::PRE_LAST_4;
			default: pre_last = ebpwm_pkg::PRE_LAST_16;
		endcase
		// Short periods have fewer than four timer cycles; act at the first.
		if (tb.period_limit >= 8'(ebpwm_pkg::DIR_LEAD_TCY - 1))
			dir_tmr = tb.period_limit - 8'(ebpwm_pkg::DIR_LEAD_TCY - 1);
		else
			dir_tmr = 8'h00;
		st_nxt = st_r;
		if (!tb.enable)
			st_nxt = '0;
		else if (st_r.pre != pre_last)
			st_nxt.pre = st_r.pre + 4'h1;
		else
		begin
			st_nxt.pre = 4'h0;
			// Time base is the timer count joined to two low phase bits.
			if (st_r.fine == {tb.period_limit, 2'h3}) // RQ2
				st_nxt.fine = 10'h000; // RQ3
			else
				st_nxt.fine = st_r.fine + 10'h001;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign tb.fine_count = st_r.fine;
	assign tb.period_start = (st_r.fine == 10'h000) && (st_r.pre == 4'h0);
	assign tb.dir_point = (st_r.fine == {dir_tmr, 2'h0}) && (st_r.pre == 4'h0); // RQ11
endmodule : ebpwm_timebase

//--- rtl/ebpwm_top.sv
`timescale 1ns/1ps
// What this block does
// RQ1: Config 00 single, 10 half-bridge, 01 full forward, 11 full reverse.
// RQ2: Time base is 8-bit timer joined with two low phase bits.
// RQ3: Period 4*(limit+1)*prescale clocks; pulse is 10-bit duty*prescale clocks.
// RQ4: Half-bridge drives only A and B; C and D undriven.
// RQ5: Half-bridge puts PWM on A and its complement on B.
// RQ6: Half-bridge holds output inactive 4*deadband clocks before going active.
// RQ7: Dead-band longer than pulse keeps that output inactive all period.
// RQ8: Forward: A active, D modulated, B and C inactive.
// RQ9: Reverse: C active, B modulated, A and D inactive.
// RQ10: Full-bridge modes apply no dead-band.
// RQ11: Direction change acts four timer cycles before period end, blanking.
// RQ12: Three-bit source field picks interrupt pin low or comparator.
// RQ13: Status bit 0 means normal, 1 means outputs shut down.
// RQ14: Shutdown event sets status; stays until firmware or auto-restart clears.
// RQ15: Shutdown forces enabled pin pairs A/C, B/D to chosen safe state.
// RQ16: Shutdown is level based and persists while level persists.
// RQ17: Firmware status writes ignored while shutdown condition present.
// RQ18: After restart the waveform resumes at next period start.
// RQ19: Auto-restart only when enabled, else firmware clears status.
// RQ20: Auto-restart clears status in hardware once condition goes away.
// RQ21: Single mode drives PWM only on steering-enabled pins.
// RQ22: Half-bridge-only build has no C and D outputs.
// RQ23: Function field low bits set polarity of pairs A/C and B/D.
// RQ24: On first enable, output waits for a new period start.
// RQ25: Dead-band inserted only on inactive-to-active transitions.
// RQ26: Encodings of source and safe-state fields are defined here.
// RQ27: Source inputs feed status through a flop; pins forced directly. Here the pins are registered too and change on the same edge as status.
module ebpwm_top
#(
	parameter bit HAS_CD = 1'b1
)
(
	input wire logic CLK_SYS_IN,
	input wire logic RESETN_IN,
	input wire logic PWM_ENABLE_IN,
	input wire logic [1:0] OUTPUT_CONFIG_FIELD_IN,
	input wire logic [1:0] POLARITY_IN,
	input wire logic [3:0] STEER_ENABLE_IN,
	input wire logic [7:0] PERIOD_LIMIT_IN,
	input wire logic [1:0] PRESCALE_SEL_IN,
	input wire logic [7:0] DUTY_HIGH_BYTE_IN,
	input wire logic [1:0] DUTY_LOW_BITS_IN,
	input wire logic [6:0] DEADBAND_COUNT_IN,
	input wire logic AUTO_RESTART_ENABLE_IN,
	input wire logic [2:0] SHUTDOWN_SOURCE_IN,
	input wire logic [1:0] PAIR_AC_SAFE_STATE_IN,
	input wire logic [1:0] PAIR_BD_SAFE_STATE_IN,
	input wire logic EXT_INT_PIN_IN,
	input wire logic COMPARATOR_IN,
	input wire logic STATUS_SET_IN,
	input wire logic STATUS_CLEAR_IN,
	output logic SHUTDOWN_STATUS_OUT,
	output logic PWM_OUT_A_OUT,
	output logic PWM_OUT_B_OUT,
	output logic PWM_OUT_C_OUT,
	output logic PWM_OUT_D_OUT,
	output logic [3:0] PWM_OE_N_OUT
);
	// -------------------------------------------------
	// State
	// -------------------------------------------------
	typedef struct packed
	{
		ebpwm_pkg::ebpwm_run_t run;
		logic status;
		logic [1:0] cfg;
		logic dir;
		logic blank;
		logic [9:0] duty;
		logic pwm;
		logic [3:0] pin;
		logic [3:0] oe_n;
	} ebpwm_st_t;
	ebpwm_st_t st_r;
	ebpwm_st_t st_nxt;

	logic cond;
	logic db_a;
	logic db_b;
	logic [3:0] act;
	logic [3:0] use_pin;
	logic [3:0] low_act;
	logic [3:0] safe;

	ebpwm_tb_if tb_bus ();

	assign tb_bus.enable = PWM_ENABLE_IN;
	assign tb_bus.period_limit = PERIOD_LIMIT_IN;
	assign tb_bus.prescale_sel = PRESCALE_SEL_IN;

	ebpwm_timebase u_timebase
	(
		.clk_in(CLK_SYS_IN),
		.resetn_in(RESETN_IN),
		.tb(tb_bus.timer)
	);

	ebpwm_deadband u_deadband
	(
		.clk_in(CLK_SYS_IN),
		.resetn_in(RESETN_IN),
		.db_enable_in(st_r.cfg == ebpwm_pkg::CFG_HALF), // RQ10
		.pwm_in(st_r.pwm),
		.count_in(DEADBAND_COUNT_IN),
		.out_a_out(db_a),
		.out_b_out(db_b)
	);

	// -------------------------------------------------
	// Helpers
	// -------------------------------------------------
	function automatic logic safe_level(input logic [1:0] code);
		safe_level = (code == ebpwm_pkg::SAFE_HIGH);
	endfunction : safe_level

	function automatic logic safe_hiz(input logic [1:0] code);
		safe_hiz = code[ebpwm_pkg::SAFE_HIZ_BIT];
	endfunction : safe_hiz

	// -------------------------------------------------
	// Next state
	// -------------------------------------------------
	always_comb
	begin
		// Pins and status both take the live level, each through its own flop, on the same edge.
		cond = (SHUTDOWN_SOURCE_IN[ebpwm_pkg::SRC_CMP_BIT] && COMPARATOR_IN) ||
			(SHUTDOWN_SOURCE_IN[ebpwm_pkg::SRC_INT_BIT] && !EXT_INT_PIN_IN); // RQ12 RQ16 RQ27
		st_nxt = st_r;

		// Shutdown status: set wins over any clear.
		if (cond || STATUS_SET_IN)
			st_nxt.status = 1'b1; // RQ14 RQ16
		else if (STATUS_CLEAR_IN)
			st_nxt.status = 1'b0; // RQ17 RQ19
		else if (AUTO_RESTART_ENABLE_IN)
			st_nxt.status = 1'b0; // RQ20

		// Duty is taken only at a period boundary; configuration there too, or early at a full-bridge direction change.
		if (tb_bus.period_start)
		begin
			st_nxt.duty = {DUTY_HIGH_BYTE_IN, DUTY_LOW_BITS_IN}; // RQ3
			st_nxt.blank = 1'b0; // RQ11
			if (!OUTPUT_CONFIG_FIELD_IN[ebpwm_pkg::CFG_FULL_BIT] ||
				!st_r.cfg[ebpwm_pkg::CFG_FULL_BIT] || st_r.run != ebpwm_pkg::RUN_ON)
			begin
				st_nxt.cfg = OUTPUT_CONFIG_FIELD_IN; // RQ1
				st_nxt.dir = OUTPUT_CONFIG_FIELD_IN[ebpwm_pkg::CFG_DIR_BIT];
			end
		end
		// Running full-bridge: a new direction is taken early, with blanking.
		if (st_r.cfg[ebpwm_pkg::CFG_FULL_BIT] &&
			OUTPUT_CONFIG_FIELD_IN[ebpwm_pkg::CFG_FULL_BIT] &&
			OUTPUT_CONFIG_FIELD_IN[ebpwm_pkg::CFG_DIR_BIT] != st_r.dir && tb_bus.dir_point)
		begin
			st_nxt.dir = OUTPUT_CONFIG_FIELD_IN[ebpwm_pkg::CFG_DIR_BIT]; // RQ11
			st_nxt.cfg = OUTPUT_CONFIG_FIELD_IN;
			st_nxt.blank = 1'b1; // RQ11
		end

		// Run sequencing.
		case (st_r.run)
			ebpwm_pkg::RUN_OFF:
				if (PWM_ENABLE_IN)
					st_nxt.run = ebpwm_pkg::RUN_WAIT;
			ebpwm_pkg::RUN_WAIT:
				if (st_r.status)
					st_nxt.run = ebpwm_pkg::RUN_SHUT;
				else if (tb_bus.period_start)
					st_nxt.run = ebpwm_pkg::RUN_ON; // RQ18 RQ24
			ebpwm_pkg::RUN_ON:
				if (st_r.status || cond)
					st_nxt.run = ebpwm_pkg::RUN_SHUT;
			ebpwm_pkg::RUN_SHUT:
				if (!st_r.status && !cond)
					st_nxt.run = ebpwm_pkg::RUN_WAIT; // RQ18
			default:
				st_nxt.run = ebpwm_pkg::RUN_OFF;
		endcase
		if (!PWM_ENABLE_IN)
			st_nxt.run = ebpwm_pkg::RUN_OFF;

		// Raw modulation: active from the period start until the duty count.
		st_nxt.pwm = (st_r.run == ebpwm_pkg::RUN_ON) && (tb_bus.fine_count < st_r.duty); // RQ3

		// Logical active levels per pin, A to D in bits 0 to 3.
		act = 4'h0;
		use_pin = 4'h0;
		case (st_r.cfg)
			ebpwm_pkg::CFG_SINGLE:
			begin
				use_pin = STEER_ENABLE_IN; // RQ21
				act = STEER_ENABLE_IN & {4{db_a}}; // RQ21
			end
			ebpwm_pkg::CFG_HALF:
			begin
				use_pin = 4'h3; // RQ4
				act = {2'h0, db_b, db_a}; // RQ4 RQ5
			end
			ebpwm_pkg::CFG_FWD:
			begin
				use_pin = 4'hf;
				act = {db_a && !st_r.blank, 2'h0, 1'b1}; // RQ8 RQ10
			end
			ebpwm_pkg::CFG_REV:
			begin
				use_pin = 4'hf;
				act = {1'b0, 1'b1, db_a && !st_r.blank, 1'b0}; // RQ9 RQ10
			end
			default:
			begin
				use_pin = 4'h0;
				act = 4'h0;
			end
		endcase
		if (!HAS_CD)
			use_pin[3:2] = 2'h0; // RQ22
		if (st_r.run != ebpwm_pkg::RUN_ON)
			act = 4'h0; // RQ24

		low_act = {POLARITY_IN[ebpwm_pkg::POL_BD_BIT], POLARITY_IN[ebpwm_pkg::POL_AC_BIT],
			POLARITY_IN[ebpwm_pkg::POL_BD_BIT], POLARITY_IN[ebpwm_pkg::POL_AC_BIT]}; // RQ23
		safe = {safe_level(PAIR_BD_SAFE_STATE_IN), safe_level(PAIR_AC_SAFE_STATE_IN),
			safe_level(PAIR_BD_SAFE_STATE_IN), safe_level(PAIR_AC_SAFE_STATE_IN)}; // RQ15 RQ26

		// Pin drive; shutdown overrides within one clock of the level.
		// Disable releases the pins on the same edge that stops the run.
		if (st_r.run == ebpwm_pkg::RUN_OFF || !PWM_ENABLE_IN)
		begin
			st_nxt.pin = 4'h0;
			st_nxt.oe_n = 4'hf;
		end
		// A firmware-raised shutdown forces the pins on the same edge as the status.
		else if (st_r.status || cond || STATUS_SET_IN)
		begin
			st_nxt.pin = safe & use_pin; // RQ15 RQ13
			st_nxt.oe_n = ~use_pin |
				{safe_hiz(PAIR_BD_SAFE_STATE_IN), safe_hiz(PAIR_AC_SAFE_STATE_IN),
				safe_hiz(PAIR_BD_SAFE_STATE_IN), safe_hiz(PAIR_AC_SAFE_STATE_IN)}; // RQ15
		end
		else
		begin
			st_nxt.pin = (act ^ low_act) & use_pin; // RQ23
			st_nxt.oe_n = ~use_pin; // RQ4 RQ21
		end
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RESETN_IN)
		begin
			st_r <= '0;
			st_r.run <= ebpwm_pkg::RUN_OFF;
			st_r.oe_n <= 4'hf;
		end
		else
			st_r <= st_nxt;
	end

	// -------------------------------------------------
	// Outputs
	// -------------------------------------------------
	assign SHUTDOWN_STATUS_OUT = st_r.status; // RQ13
	assign PWM_OUT_A_OUT = st_r.pin[0];
	assign PWM_OUT_B_OUT = st_r.pin[1];
	assign PWM_OUT_C_OUT = st_r.pin[2];
	assign PWM_OUT_D_OUT = st_r.pin[3];
	assign PWM_OE_N_OUT = st_r.oe_n;
endmodule : ebpwm_top

//--- sim/ebpwm_bridge_model.sv
`timescale 1ns/1ps
module ebpwm_bridge_model
(
	input wire logic half_in,
	input wire logic [3:0] pin_in,
	input wire logic [3:0] oe_n_in,
	output logic [3:0] line_out,
	output logic overlap_out
);
	// ---------------------------------
	// Switch inputs
	// ---------------------------------
	// Released pins fall to the board pull-downs, so a stale level never reads as driven.
	assign line_out = pin_in & ~oe_n_in;
	// Both half-bridge switches on together would short the supply.
	assign overlap_out = half_in & line_out[0] & line_out[1];
endmodule : ebpwm_bridge_model

//--- sim/ebpwm_top_checker.sv
`timescale 1ns/1ps
module ebpwm_top_checker
(
	input wire logic CLK_SYS_IN,
	input wire logic RESETN_IN,
	input wire logic PWM_ENABLE_IN,
	input wire logic AUTO_RESTART_ENABLE_IN,
	input wire logic [2:0] SHUTDOWN_SOURCE_IN,
	input wire logic [1:0] PAIR_AC_SAFE_STATE_IN,
	input wire logic [1:0] PAIR_BD_SAFE_STATE_IN,
	input wire logic EXT_INT_PIN_IN,
	input wire logic COMPARATOR_IN,
	input wire logic STATUS_SET_IN,
	input wire logic STATUS_CLEAR_IN,
	input wire logic SHUTDOWN_STATUS_OUT,
	input wire logic PWM_OUT_A_OUT,
	input wire logic [3:0] PWM_OE_N_OUT
);
	logic cond;
	logic st;
	logic en;
	assign cond = (SHUTDOWN_SOURCE_IN[0] & COMPARATOR_IN) | (SHUTDOWN_SOURCE_IN[1] & ~EXT_INT_PIN_IN);
	assign st = SHUTDOWN_STATUS_OUT;
	assign en = PWM_ENABLE_IN;
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RESETN_IN);
	cmp_shut_a: assert property (en && SHUTDOWN_SOURCE_IN[0] && COMPARATOR_IN |=> st)
		else $error("comparator shutdown missed");
	int_shut_a: assert property (en && SHUTDOWN_SOURCE_IN[1] && !EXT_INT_PIN_IN |-> ##1 st)
		else $error("pin shutdown missed");
	level_hold_a: assert property (en && st && cond |=> st)
		else $error("status dropped under condition");
	safe_drive_a: assert property (st && !PWM_OE_N_OUT[0] |-> !PAIR_AC_SAFE_STATE_IN[1] && PWM_OUT_A_OUT == PAIR_AC_SAFE_STATE_IN[0])
		else $error("pair A/C safe level wrong");
	safe_float_a: assert property (st && PAIR_BD_SAFE_STATE_IN[1] |-> PWM_OE_N_OUT[1] && PWM_OE_N_OUT[3])
		else $error("pair B/D not released");
	off_release_a: assert property (!en |=> PWM_OE_N_OUT == 4'hf)
		else $error("pins driven while off");
	reset_idle_a: assert property ($rose(RESETN_IN) |-> !st && PWM_OE_N_OUT == 4'hf)
		else $error("not idle after reset");
	auto_clear_a: assert property (AUTO_RESTART_ENABLE_IN && en && st && !cond && !STATUS_SET_IN |=> !st)
		else $error("auto restart missed");
	fw_hold_a: assert property (!AUTO_RESTART_ENABLE_IN && en && st && !STATUS_CLEAR_IN |=> st)
		else $error("status cleared without firmware");
	fw_clear_a: assert property (en && !cond && STATUS_CLEAR_IN && !STATUS_SET_IN |=> !st)
		else $error("firmware clear ignored");
endmodule : ebpwm_top_checker
bind ebpwm_top ebpwm_top_checker chk_u (.*);

//--- sim/ebpwm_top_tb.sv
`timescale 1ns/1ps
module ebpwm_top_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic en = 1'b0;
	logic [1:0] cfg = 2'h0;
	logic [3:0] steer = 4'h0;
	logic [1:0] presc = 2'h0;
	logic [9:0] duty = 10'h000;
	logic [6:0] db = 7'h00;
	logic auto_rs = 1'b0;
	logic [2:0] src = 3'h0;
	logic [1:0] safe_ac = 2'h1;
	logic [1:0] safe_bd = 2'h2;
	logic int_pin = 1'b1;
	logic cmp = 1'b0;
	logic fw_set = 1'b0;
	logic fw_clr = 1'b0;
	logic status;
	logic [3:0] pin;
	logic [3:0] oe_n;
	logic [3:0] lvl;
	logic overlap;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_ovl = 0;
	int cycles = 0;
	int hi;
	int per;
	ebpwm_top dut_u
	(
		.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .PWM_ENABLE_IN(en), .OUTPUT_CONFIG_FIELD_IN(cfg),
		.POLARITY_IN(2'h0), .STEER_ENABLE_IN(steer), .PERIOD_LIMIT_IN(8'h03), .PRESCALE_SEL_IN(presc),
		.DUTY_HIGH_BYTE_IN(duty[9:2]), .DUTY_LOW_BITS_IN(duty[1:0]), .DEADBAND_COUNT_IN(db),
		.AUTO_RESTART_ENABLE_IN(auto_rs), .SHUTDOWN_SOURCE_IN(src), .PAIR_AC_SAFE_STATE_IN(safe_ac),
		.PAIR_BD_SAFE_STATE_IN(safe_bd), .EXT_INT_PIN_IN(int_pin), .COMPARATOR_IN(cmp),
		.STATUS_SET_IN(fw_set), .STATUS_CLEAR_IN(fw_clr), .SHUTDOWN_STATUS_OUT(status),
		.PWM_OUT_A_OUT(pin[0]), .PWM_OUT_B_OUT(pin[1]), .PWM_OUT_C_OUT(pin[2]), .PWM_OUT_D_OUT(pin[3]),
		.PWM_OE_N_OUT(oe_n)
	);
	ebpwm_bridge_model drv_u
	(
		.half_in(cfg == ebpwm_pkg::CFG_HALF), .pin_in(pin), .oe_n_in(oe_n), .line_out(lvl), .overlap_out(overlap)
	);
	// ---------------------------------
	// Clock and watchdog
	// ---------------------------------
	initial
	begin
		forever #20 clk = ~clk;
	end
	always @(negedge clk)
	begin
		cycles++;
		n_ovl += (overlap === 1'b1);
		if (cycles == 20000)
		begin
			n_mismatch++;
			finish_test();
		end
	end
	// ---------------------------------
	// Shared tasks
	// ---------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : chk
	task finish_test;
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	// Bounded waits, so a pin that never moves ends as a count of 0 or 400, not a hang.
	task meas(input int i);
		int k;
		k = 0;
		hi = 0;
		while (lvl[i] !== 1'b1 && k < 400)
		begin
			@(negedge clk);
			k++;
		end
		while (lvl[i] === 1'b1 && hi < 400)
		begin
			@(negedge clk);
			hi++;
		end
		per = hi;
		while (lvl[i] !== 1'b1 && per < 400)
		begin
			@(negedge clk);
			per++;
		end
	endtask : meas
	task setup(input logic [1:0] c, input logic [9:0] d, input logic [6:0] b, input logic [1:0] p);
		en = 1'b0;
		repeat (2) @(negedge clk);
		cfg = c;
		steer = 4'h1;
		duty = d;
		db = b;
		presc = p;
		en = 1'b1;
		meas(c == ebpwm_pkg::CFG_REV ? 1 : (c == ebpwm_pkg::CFG_FWD ? 3 : 0));
	endtask : setup
	// ---------------------------------
	// Scenarios
	// ---------------------------------
	task t_single;
		for (int p = 0; p < 2; p++)
		begin
			setup(ebpwm_pkg::CFG_SINGLE, 10'h006, 7'h00, 2'(p));
			meas(0);
			chk(hi, p ? 24 : 6);
			chk(per, p ? 64 : 16);
			chk(oe_n, 4'he);
		end
	endtask : t_single
	task t_half;
		setup(ebpwm_pkg::CFG_HALF, 10'h008, 7'h01, 2'h0);
		meas(0);
		chk(hi, 4);
		chk(oe_n, 4'hc);
		meas(1);
		chk(hi, 4);
		chk(per, 16);
		db = 7'h03;
		meas(0);
		meas(0);
		chk(hi, 0);
		chk(n_ovl, 0);
	endtask : t_half
	task t_full;
		setup(ebpwm_pkg::CFG_FWD, 10'h006, 7'h01, 2'h0);
		meas(3);
		chk(hi, 6);
		chk(lvl, 4'h9);
		setup(ebpwm_pkg::CFG_REV, 10'h006, 7'h01, 2'h0);
		meas(1);
		chk(hi, 6);
		chk(lvl, 4'h6);
	endtask : t_full
	task t_shut;
		src = 3'h1;
		cmp = 1'b1;
		repeat (2) @(negedge clk);
		chk(status, 1);
		chk(lvl, 4'h5);
		fw_clr = 1'b1;
		repeat (2) @(negedge clk);
		chk(status, 1);
		fw_clr = 1'b0;
		cmp = 1'b0;
		repeat (3) @(negedge clk);
		chk(status, 1);
		fw_clr = 1'b1;
		@(negedge clk);
		fw_clr = 1'b0;
		@(negedge clk);
		chk(status, 0);
		auto_rs = 1'b1;
		src = 3'h2;
		int_pin = 1'b0;
		repeat (2) @(negedge clk);
		chk(status, 1);
		int_pin = 1'b1;
		repeat (2) @(negedge clk);
		chk(status, 0);
		fw_set = 1'b1;
		@(negedge clk);
		chk(status, 1);
		fw_set = 1'b0;
		meas(1);
		meas(1);
		chk(hi, 6);
	endtask : t_shut
	initial
	begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		t_single();
		t_half();
		t_full();
		t_shut();
		finish_test();
	end
endmodule : ebpwm_top_tb
